// [logic/failover_selector.sv]
`default_nettype none

// Summary of operation
// - revertive mode returns to A when valid
// - non-revertive holds B until revert command
// - manual select of B persists; select of A resumes auto failover
// - latching relays keep selection over power loss
// - GPI inputs change source; monitor drives them
// - four buffered outputs follow selection, reclock optional
// - buffered path independent; relay path stays passive
// - two GPIs select A or B on falling edge
// - two status contacts show selected input
module failover_selector #(
  parameter int RELAY_PULSE_CYCLES = failover_pkg::RELAY_PULSE_CYCLES,
  parameter int NUM_OUTPUTS = failover_pkg::NUM_BUFFERED
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic valid_a_in,
  input wire logic valid_b_in,
  input wire logic gpi_a_n_in,
  input wire logic gpi_b_n_in,
  input wire logic relay_sense_in,
  output logic relay_set_a_out,
  output logic relay_set_b_out,
  output failover_pkg::input_sel_t route_select_out,
  output logic [NUM_OUTPUTS-1:0] reclock_en_out,
  output logic buffer_drive_out,
  output logic gpo_a_out,
  output logic gpo_b_out,
  output logic irq_out
);
  import failover_pkg::*;

  typedef struct packed {
    route_state_t route;
    input_sel_t sel;
    logic capture_pending;
    logic [31:0] control;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_enable;
    logic gpi_a_prev;
    logic gpi_b_prev;
    logic valid_a_prev;
    logic wr_pending;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic gpo_a;
    logic gpo_b;
    logic buffer_drive;
    logic irq;
  } selector_state_t;

  selector_state_t state_reg;
  selector_state_t state_next;

  logic pick_a;
  logic pick_b;
  logic revert_cmd;
  logic fall_a;
  logic fall_b;
  logic quiet;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clear;

  relay_if rif ();

  relay_pulser #(
    .PULSE_CYCLES(RELAY_PULSE_CYCLES)
  ) u_pulser (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .rif(rif)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic input_sel_t route_to_input(input route_state_t route);
    return (route == ON_PRIMARY) ? INPUT_A : INPUT_B;
  endfunction : route_to_input

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr,
                                            input selector_state_t s,
                                            input logic busy);
    logic [31:0] w;
    w = '0;
    unique case (addr)
      OFF_CONTROL: w = s.control;
      OFF_STATUS: begin
        w[ST_SELECT_BIT] = s.sel;
        w[ST_VALID_A_BIT] = valid_a_in;
        w[ST_VALID_B_BIT] = valid_b_in;
        w[ST_RELAY_BUSY_BIT] = busy;
        w[ST_ROUTE_LSB +: 2] = s.route;
      end
      OFF_EVENT_STATUS: w[EV_W-1:0] = s.ev_status;
      OFF_EVENT_ENABLE: w[EV_W-1:0] = s.ev_enable;
      default: w = '0;
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pick_a = 1'b0;
    pick_b = 1'b0;
    revert_cmd = 1'b0;
    ev_clear = '0;

    // write data phase
    if (state_reg.wr_pending) begin
      unique case (state_reg.wr_addr)
        OFF_CONTROL: state_next.control = hwdata_in;
        OFF_COMMAND: begin
          pick_a = hwdata_in[CMD_SELECT_A_BIT];
          pick_b = hwdata_in[CMD_SELECT_B_BIT];
          revert_cmd = hwdata_in[CMD_REVERT_BIT];
        end
        OFF_EVENT_CLEAR: ev_clear = hwdata_in[EV_W-1:0];
        OFF_EVENT_ENABLE: state_next.ev_enable = hwdata_in[EV_W-1:0];
        default: ;
      endcase
    end

    // gpi strobes act on the high-to-low edge only
    fall_a = state_reg.gpi_a_prev && !gpi_a_n_in;
    fall_b = state_reg.gpi_b_prev && !gpi_b_n_in;
    state_next.gpi_a_prev = gpi_a_n_in;
    state_next.gpi_b_prev = gpi_b_n_in;
    pick_a = pick_a | fall_a;
    pick_b = pick_b | fall_b;
    quiet = !pick_a && !pick_b && !revert_cmd && !state_reg.capture_pending;

    unique case (state_reg.route)
      ON_PRIMARY: begin
        if (state_reg.control[CTL_AUTO_BIT] && !valid_a_in) begin
          state_next.route = FAILED_OVER;
        end
      end
      FAILED_OVER: begin
        if (state_reg.control[CTL_REVERTIVE_BIT] && valid_a_in) begin
          state_next.route = ON_PRIMARY;
        end else if (revert_cmd) begin
          state_next.route = ON_PRIMARY;
        end
      end
      MANUAL_BACKUP: begin
        if (revert_cmd) begin
          state_next.route = ON_PRIMARY;
        end
      end
      default: state_next.route = ON_PRIMARY;
    endcase

    // commands beat automatic decisions; A wins a tie
    if (pick_a) begin
      state_next.route = ON_PRIMARY;
    end else if (pick_b) begin
      state_next.route = MANUAL_BACKUP;
    end

    // after reset adopt the position the latching relay kept
    if (state_reg.capture_pending) begin
      state_next.capture_pending = 1'b0;
      state_next.route = relay_sense_in ? MANUAL_BACKUP : ON_PRIMARY;
      state_next.buffer_drive = 1'b1;
    end

    state_next.sel = route_to_input(state_next.route);
    state_next.gpo_a = (state_next.sel == INPUT_A);
    state_next.gpo_b = (state_next.sel == INPUT_B);

    // events; a set in the same cycle as its clear survives
    ev_set = '0;
    ev_set[EV_SWITCH_BIT] = (state_next.sel != state_reg.sel) && !state_reg.capture_pending;
    ev_set[EV_PRIMARY_LOST_BIT] = state_reg.valid_a_prev && !valid_a_in;
    ev_set[EV_PRIMARY_BACK_BIT] = !state_reg.valid_a_prev && valid_a_in;
    ev_set[EV_GPI_BIT] = fall_a | fall_b;
    state_next.valid_a_prev = valid_a_in;
    state_next.ev_status = (state_reg.ev_status & ~ev_clear) | ev_set;
    state_next.irq = |(state_next.ev_status & state_next.ev_enable);

    // address phase; zero wait states, always okay
    state_next.ready = 1'b1;
    state_next.wr_pending = 1'b0;
    state_next.rdata = '0;
    if (hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in) begin
      state_next.wr_pending = hwrite_in;
      state_next.wr_addr = haddr_in[ADDR_W-1:0];
      if (!hwrite_in) begin
        state_next.rdata = read_word(haddr_in[ADDR_W-1:0], state_next, rif.busy);
      end
    end

    if (rst_in) begin
      state_next = '0;
      state_next.route = ON_PRIMARY;
      state_next.sel = INPUT_A;
      state_next.capture_pending = 1'b1;
      state_next.control = CONTROL_RESET;
      state_next.gpi_a_prev = 1'b1;
      state_next.gpi_b_prev = 1'b1;
      // track the pin so the first edge after reset shows no false primary event
      state_next.valid_a_prev = valid_a_in;
      state_next.ready = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rif.select = state_reg.sel;
  assign rif.capture = state_reg.capture_pending;
  assign rif.captured = input_sel_t'(relay_sense_in);

  // relay path is only ever switched, never driven with signal
  assign relay_set_a_out = rif.coil_a;
  assign relay_set_b_out = rif.coil_b;
  assign route_select_out = state_reg.sel;
  assign reclock_en_out = state_reg.control[CTL_RECLOCK_LSB +: NUM_OUTPUTS];
  assign buffer_drive_out = state_reg.buffer_drive;
  assign gpo_a_out = state_reg.gpo_a;
  assign gpo_b_out = state_reg.gpo_b;
  assign irq_out = state_reg.irq;
  assign hrdata_out = state_reg.rdata;
  assign hreadyout_out = state_reg.ready;
  assign hresp_out = HRESP_OKAY;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_failover_auto: assert property (
    state_reg.route == ON_PRIMARY && state_reg.control[CTL_AUTO_BIT] && !valid_a_in && quiet
    && !rif.busy && !$past(rif.busy) && $past(route_select_out) == INPUT_A
    |=> route_select_out == INPUT_B ##1 relay_set_b_out)
    else $error("no failover to backup on invalid primary");

  a_revert_auto: assert property (
    state_reg.route == FAILED_OVER && state_reg.control[CTL_REVERTIVE_BIT]
    && valid_a_in && quiet
    |=> route_select_out == INPUT_A && gpo_a_out)
    else $error("revertive mode did not return to primary");

  a_nonrevert_hold: assert property (
    state_reg.route == FAILED_OVER && !state_reg.control[CTL_REVERTIVE_BIT] && quiet
    |=> state_reg.route == FAILED_OVER && route_select_out == INPUT_B)
    else $error("non-revertive mode left backup without command");

  a_revert_command: assert property (
    revert_cmd && !pick_b && !state_reg.capture_pending && state_reg.route != ON_PRIMARY
    |=> route_select_out == INPUT_A)
    else $error("revert command ignored");

  a_manual_persist: assert property (
    state_reg.route == MANUAL_BACKUP && quiet [*2]
    |=> route_select_out == INPUT_B)
    else $error("manual backup selection not held");

  a_capture_relay: assert property (
    state_reg.capture_pending && !rst_in
    |=> route_select_out == input_sel_t'($past(relay_sense_in)) && !relay_set_a_out
        && !relay_set_b_out)
    else $error("selection not taken from latched relay");

  a_gpi_edge: assert property (
    fall_b && !pick_a && !state_reg.capture_pending |=> route_select_out == INPUT_B)
    else $error("gpi falling edge did not select backup");

  a_gpi_level: assert property (
    !gpi_b_n_in && !$past(gpi_b_n_in) && state_reg.route == ON_PRIMARY && valid_a_in
    && !state_reg.wr_pending && !state_reg.capture_pending |=> route_select_out == INPUT_A)
    else $error("gpi low level acted without an edge");

  a_gpo_status: assert property (
    $changed(route_select_out) |-> gpo_b_out == (route_select_out == INPUT_B)
    && gpo_a_out != gpo_b_out)
    else $error("status contacts disagree with selection");

  a_event_sticky: assert property (
    ev_set[EV_SWITCH_BIT] |=> state_reg.ev_status[EV_SWITCH_BIT])
    else $error("switch event lost");

  c_failover: cover property (state_reg.route == ON_PRIMARY ##1 state_reg.route == FAILED_OVER);
  c_revert: cover property (state_reg.route == FAILED_OVER ##1 state_reg.route == ON_PRIMARY);
  c_manual_b: cover property (state_reg.route == MANUAL_BACKUP && relay_set_b_out);
  c_gpi_a: cover property (fall_a && state_reg.route != ON_PRIMARY);

endmodule : failover_selector

`default_nettype wire

// [logic/failover_pkg.sv]
`default_nettype none

package failover_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COMMAND = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EVENT_CLEAR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVENT_ENABLE = 8'h14;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int CTL_AUTO_BIT = 0;
  localparam int CTL_REVERTIVE_BIT = 1;
  localparam int CTL_RECLOCK_LSB = 4;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_00f3;

  localparam int CMD_SELECT_A_BIT = 0;
  localparam int CMD_SELECT_B_BIT = 1;
  localparam int CMD_REVERT_BIT = 2;

  localparam int ST_SELECT_BIT = 0;
  localparam int ST_VALID_A_BIT = 1;
  localparam int ST_VALID_B_BIT = 2;
  localparam int ST_RELAY_BUSY_BIT = 3;
  localparam int ST_ROUTE_LSB = 4;

  localparam int EV_W = 4;
  localparam int EV_SWITCH_BIT = 0;
  localparam int EV_PRIMARY_LOST_BIT = 1;
  localparam int EV_PRIMARY_BACK_BIT = 2;
  localparam int EV_GPI_BIT = 3;

  localparam int NUM_BUFFERED = 4;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int RELAY_PULSE_TIME_MS = 10;
  localparam int RELAY_PULSE_CYCLES =
    (RELAY_PULSE_TIME_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    INPUT_A = 1'b0,
    INPUT_B = 1'b1
  } input_sel_t;

  typedef enum logic [1:0] {
    ON_PRIMARY = 2'b00,
    FAILED_OVER = 2'b01,
    MANUAL_BACKUP = 2'b10
  } route_state_t;

endpackage : failover_pkg

`default_nettype wire

// [logic/relay_if.sv]
`default_nettype none

interface relay_if;
  import failover_pkg::*;
  input_sel_t select;
  logic capture;
  input_sel_t captured;
  logic coil_a;
  logic coil_b;
  logic busy;

  modport ctrl (output select, output capture, output captured,
                input coil_a, input coil_b, input busy);
  modport driver (input select, input capture, input captured,
                  output coil_a, output coil_b, output busy);
endinterface : relay_if

`default_nettype wire

// [logic/relay_pulser.sv]
`default_nettype none

module relay_pulser #(
  parameter int PULSE_CYCLES = failover_pkg::RELAY_PULSE_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  relay_if.driver rif
);
  import failover_pkg::*;

  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] LAST_COUNT = CW'(PULSE_CYCLES - 1);

  typedef struct packed {
    input_sel_t last;
    logic coil_a;
    logic coil_b;
    logic [CW-1:0] count;
  } pulser_state_t;

  pulser_state_t state_reg;
  pulser_state_t state_next;

  // ----------------------------------------------------------------
  // coil pulse sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (rst_in) begin
      state_next = '0;
    end else if (rif.capture) begin
      // relay already sits where it was left; adopt it without a pulse
      state_next.last = rif.captured;
      state_next.coil_a = 1'b0;
      state_next.coil_b = 1'b0;
      state_next.count = '0;
    end else if (state_reg.coil_a || state_reg.coil_b) begin
      if (state_reg.count == LAST_COUNT) begin
        state_next.coil_a = 1'b0;
        state_next.coil_b = 1'b0;
        state_next.count = '0;
      end else begin
        state_next.count = state_reg.count + 1'b1;
      end
    end else if (rif.select != state_reg.last) begin
      state_next.last = rif.select;
      state_next.coil_a = (rif.select == INPUT_A);
      state_next.coil_b = (rif.select == INPUT_B);
      state_next.count = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    state_reg <= state_next;
  end

  assign rif.coil_a = state_reg.coil_a;
  assign rif.coil_b = state_reg.coil_b;
  assign rif.busy = state_reg.coil_a | state_reg.coil_b;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_pulse_on_change: assert property (
    !rif.capture && !rif.busy && rif.select != state_reg.last
    |=> rif.busy && rif.coil_b == ($past(rif.select) == INPUT_B))
    else $error("relay coil not pulsed after selection change");

  a_pulse_quiet: assert property (
    !rif.capture && !rif.busy && rif.select == state_reg.last |=> !rif.busy)
    else $error("relay coil pulsed without selection change");

  a_coils_exclusive: assert property (
    !(rif.coil_a && rif.coil_b))
    else $error("both relay coils energised");

endmodule : relay_pulser

`default_nettype wire

// [sim/video_source_model.sv]
`default_nettype none

module video_source_model (
  input wire logic clock_in,
  input wire logic relay_set_a_in,
  input wire logic relay_set_b_in,
  output logic valid_a_out,
  output logic valid_b_out,
  output logic gpi_a_n_out,
  output logic gpi_b_n_out,
  output logic relay_sense_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic relay_pos_reg;

  initial begin
    valid_a_out = 1'b1;
    valid_b_out = 1'b1;
    gpi_a_n_out = 1'b1;
    gpi_b_n_out = 1'b1;
    relay_pos_reg = 1'b0;
  end

  // ----------------------------------------------------------------
  // latching relay: coil pulse moves it, nothing else does
  // ----------------------------------------------------------------
  always @(posedge clock_in) begin
    if (relay_set_a_in === 1'b1) begin
      relay_pos_reg <= 1'b0;
    end else if (relay_set_b_in === 1'b1) begin
      relay_pos_reg <= 1'b1;
    end
  end

  assign relay_sense_out = relay_pos_reg;

  task set_valid(input logic a, input logic b);
    valid_a_out <= a;
    valid_b_out <= b;
  endtask : set_valid

  // external monitor drives the contacts; pull-up makes idle high
  task gpi_level(input logic a_n, input logic b_n);
    gpi_a_n_out <= a_n;
    gpi_b_n_out <= b_n;
  endtask : gpi_level
endmodule : video_source_model

`default_nettype wire

// [sim/tb.sv]
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import failover_pkg::*;

  localparam int PULSE = 4;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, valid_a, valid_b, gpi_a_n, gpi_b_n, sense;
  logic set_a, set_b, buf_drive, gpo_a, gpo_b, irq;
  input_sel_t route_sel;
  logic [3:0] reclock_en;
  int err_total = 0;
  int n_compared = 0;
  int na, nb;

  always #50 clock_in = ~clock_in;

  failover_selector #(.RELAY_PULSE_CYCLES(PULSE), .NUM_OUTPUTS(4)) failover_selector_i (
    .clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .valid_a_in(valid_a), .valid_b_in(valid_b),
    .gpi_a_n_in(gpi_a_n), .gpi_b_n_in(gpi_b_n), .relay_sense_in(sense),
    .relay_set_a_out(set_a), .relay_set_b_out(set_b), .route_select_out(route_sel),
    .reclock_en_out(reclock_en), .buffer_drive_out(buf_drive), .gpo_a_out(gpo_a),
    .gpo_b_out(gpo_b), .irq_out(irq));

  video_source_model video_source_model_i (
    .clock_in(clock_in), .relay_set_a_in(set_a), .relay_set_b_in(set_b),
    .valid_a_out(valid_a), .valid_b_out(valid_b), .gpi_a_n_out(gpi_a_n),
    .gpi_b_n_out(gpi_b_n), .relay_sense_out(sense));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task report_and_stop();
    $display("errors=%0d compared=%0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task cycles(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cycles

  task wait_ready();
    do @(posedge clock_in); while (hreadyout !== 1'b1);
  endtask : wait_ready

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask : rd_chk

  task count_coils(input int n);
    na = 0;
    nb = 0;
    repeat (n) begin
      @(posedge clock_in);
      na += (set_a === 1'b1);
      nb += (set_b === 1'b1);
    end
  endtask : count_coils

  task do_reset();
    rst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    chk(buf_drive, 32'h0);
    rst_in <= 1'b0;
    cycles(2);
  endtask : do_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_capture();
    chk(buf_drive, 32'h1);
    chk(hresp, 32'h0);
    chk(reclock_en, 32'hf);
    chk(route_sel, INPUT_A);
    chk({gpo_a, gpo_b}, 32'h2);
    rd_chk(OFF_CONTROL, 32'h0000_00f3);
    rd_chk(OFF_EVENT_ENABLE, 32'h0);
    rd_chk(8'h20, 32'h0);
    count_coils(8);
    chk(na + nb, 32'h0);
  endtask : t_capture

  task t_revertive();
    wr(OFF_EVENT_ENABLE, 32'hf);
    video_source_model_i.set_valid(1'b0, 1'b1);
    cycles(2);
    chk(route_sel, INPUT_B);
    chk({gpo_a, gpo_b}, 32'h1);
    chk(irq, 32'h1);
    count_coils(12);
    chk({na[7:0], nb[7:0]}, {8'h0, 8'(PULSE)});
    rd_chk(OFF_STATUS, 32'h15);
    rd_chk(OFF_EVENT_STATUS, 32'h3);
    video_source_model_i.set_valid(1'b1, 1'b1);
    cycles(2);
    chk(route_sel, INPUT_A);
    count_coils(12);
    chk({na[7:0], nb[7:0]}, {8'(PULSE), 8'h0});
    rd_chk(OFF_EVENT_STATUS, 32'h7);
    wr(OFF_EVENT_CLEAR, 32'hf);
    rd_chk(OFF_EVENT_STATUS, 32'h0);
    chk(irq, 32'h0);
  endtask : t_revertive

  task t_nonrevertive();
    wr(OFF_CONTROL, 32'hf1);
    video_source_model_i.set_valid(1'b0, 1'b1);
    cycles(2);
    chk(route_sel, INPUT_B);
    video_source_model_i.set_valid(1'b1, 1'b1);
    cycles(12);
    chk(route_sel, INPUT_B);
    wr(OFF_COMMAND, 32'h4);
    cycles(1);
    chk(route_sel, INPUT_A);
    count_coils(12);
    chk(na, PULSE);
  endtask : t_nonrevertive

  task t_manual_power_loss();
    wr(OFF_COMMAND, 32'h2);
    cycles(1);
    chk(route_sel, INPUT_B);
    count_coils(12);
    chk(nb, PULSE);
    rd_chk(OFF_STATUS, 32'h27);
    do_reset();
    chk(route_sel, INPUT_B);
    chk({gpo_a, gpo_b}, 32'h1);
    count_coils(12);
    chk(na + nb, 32'h0);
    chk(route_sel, INPUT_B);
  endtask : t_manual_power_loss

  task t_gpi();
    video_source_model_i.gpi_level(1'b0, 1'b1);
    cycles(3);
    chk(route_sel, INPUT_A);
    rd_chk(OFF_EVENT_STATUS, 32'h9);
    video_source_model_i.gpi_level(1'b1, 1'b0);
    cycles(3);
    chk(route_sel, INPUT_B);
    wr(OFF_COMMAND, 32'h1);
    cycles(3);
    chk(route_sel, INPUT_A);
    video_source_model_i.gpi_level(1'b1, 1'b1);
    wr(OFF_COMMAND, 32'h2);
    cycles(2);
    video_source_model_i.gpi_level(1'b0, 1'b0);
    cycles(3);
    chk(route_sel, INPUT_A);
    video_source_model_i.gpi_level(1'b1, 1'b1);
  endtask : t_gpi

  task t_reclock();
    wr(OFF_CONTROL, 32'h53);
    cycles(2);
    chk(reclock_en, 32'h5);
    chk(buf_drive, 32'h1);
    rd_chk(OFF_CONTROL, 32'h53);
    rd_chk(OFF_COMMAND, 32'h0);
  endtask : t_reclock

  initial begin
    do_reset();
    t_capture();
    t_revertive();
    t_nonrevertive();
    t_manual_power_loss();
    t_gpi();
    t_reclock();
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge clock_in);
    err_total++;
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
